// *** hw/bps_defines.svh ***
// Constants of the buck protection sequencer: counts, thresholds, resets.
// Assumes one system clock of 200 MHz and a switching-cycle tick input.
`ifndef BPS_DEFINES_SVH
`define BPS_DEFINES_SVH

// ============================================================
// Clock and watchdog timing
`define BPS_CLK_PERIOD_NS  5
`define BPS_WDOG_NS        250
`define BPS_WDOG_CYCLES    (`BPS_WDOG_NS / `BPS_CLK_PERIOD_NS)

// ============================================================
// Soft-start and power-good timing in switching cycles
`define BPS_SS_DELAY_TICKS 11'd1024
`define BPS_SS_RAMP_TICKS  11'd1024
`define BPS_UV_ARM_LEVEL   11'd820
`define BPS_PG_DELAY_TICKS 2'd3

// ============================================================
// Overcurrent latch-off count
`define BPS_OC_LIMIT       3'd7

// ============================================================
// Reset values
`define BPS_REF_RESET      11'h000
`define BPS_CNT_RESET      11'h000

`endif

// *** hw/bps_pkg.sv ***
// Types of the buck protection sequencer.
// Assumes the constants header is included by the design files.
package bps_pkg;

  // ============================================================
  // Sequencer states, one-hot.
  typedef enum logic [5:0] {
    BPS_ST_OFF     = 6'b000001,
    BPS_ST_DELAY   = 6'b000010,
    BPS_ST_RAMP    = 6'b000100,
    BPS_ST_PG_WAIT = 6'b001000,
    BPS_ST_RUN     = 6'b010000,
    BPS_ST_FAULT   = 6'b100000
  } bps_state_t;

endpackage : bps_pkg

// *** hw/bps_sequencer.sv ***
// Protection and gate-command sequencer of a synchronous buck controller.
// Assumes comparator levels and a one-cycle switching tick from outside.
// Functional notes
// RULE1 - Power-good low outside the output window.
// RULE2 - Power-good rises three switching cycles after ramp.
// RULE3 - Undervoltage after soft-start latches both switches off.
// RULE4 - Overvoltage: high off, low on until half.
// RULE5 - In fault, overvoltage still turns low side on.
// RULE6 - Disabled overvoltage turns low side on, latched.
// RULE7 - Enable rising clears guard, starts soft-start.
// RULE8 - Undervoltage in soft-start restarts the sequence.
// RULE9 - Power-good drops in the fault's own cycle.
// RULE10 - Overcurrent forces low side until next tick.
// RULE11 - Seven consecutive overcurrent cycles latch off.
// RULE12 - Cycling supply or enable clears fault latches.
// RULE13 - Dead time waits on switch node, gate.
// RULE14 - Watchdog turns low side on anyway.
// RULE15 - Soft-start: 1024 cycles wait, 1024 ramp.
// RULE16 - Undervoltage armed from 80 percent of ramp.
// RULE17 - Loop keeps low side off until first pulse.
// RULE18 - Clean cycle clears overcurrent count; inputs synchronised.
`timescale 1ns/1ps
`default_nettype none
`include "bps_defines.svh"

module bps_sequencer #(
  parameter logic [10:0] SS_DELAY_TICKS = `BPS_SS_DELAY_TICKS,
  parameter logic [10:0] SS_RAMP_TICKS  = `BPS_SS_RAMP_TICKS,
  parameter logic [10:0] UV_ARM_LEVEL   = `BPS_UV_ARM_LEVEL,
  parameter logic [1:0]  PG_DELAY_TICKS = `BPS_PG_DELAY_TICKS,
  parameter logic [2:0]  OC_LIMIT       = `BPS_OC_LIMIT,
  parameter logic [7:0]  WDOG_CYCLES    = 8'(`BPS_WDOG_CYCLES)
) (
  // Clock and reset.
  input  wire logic  clk_sys,
  input  wire logic  nrst,
  // Supply and enable.
  input  wire logic  enable_in,
  input  wire logic  supply_ok,
  // Switching clock tick and loop demand.
  input  wire logic  switch_tick,
  input  wire logic  pwm_demand,
  // Output-sense comparators.
  input  wire logic  output_sense_over,
  input  wire logic  output_sense_under,
  input  wire logic  output_sense_below_half,
  // Current-sense comparator on plus minus minus.
  input  wire logic  current_sense_over,
  // Dead-time sense comparators.
  input  wire logic  switch_node_low,
  input  wire logic  low_gate_drive_low,
  // Switch commands.
  output logic       high_side_switch,
  output logic       low_side_switch,
  // Status.
  output logic       power_good_flag,
  output logic [10:0] reference_level,
  output logic       undervoltage_fault,
  output logic       overvoltage_fault,
  output logic       overcurrent_fault,
  output logic       disabled_overvoltage_guard
);
  import bps_pkg::*;

  // ============================================================
  // Reset release and input synchronisation
  logic       rst_n_q1;
  logic       rst_n_q2;
  logic [9:0] raw_in;
  logic [9:0] syn;

  // Reset asserts at once and releases through two flops.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_n_q1 <= 1'b0;
      rst_n_q2 <= 1'b0;
    end else begin
      rst_n_q1 <= 1'b1;
      rst_n_q2 <= rst_n_q1;
    end
  end

  // Gather the enable, supply, tick and demand inputs and the comparator levels for the synchroniser.
  assign raw_in = {enable_in, supply_ok, switch_tick, pwm_demand,
                   output_sense_over, output_sense_under,
                   output_sense_below_half, current_sense_over,
                   switch_node_low, low_gate_drive_low};

  bps_sync #(.WIDTH(10)) u_sync ( // RULE18
    .clk_sys (clk_sys),
    .rst_n   (rst_n_q2),
    .d       (raw_in),
    .q       (syn)
  );

  logic en_s, sup_s, tick_s, pwm_s, ov_s, uv_s, half_s, oc_s, node_s, lg_s;
  assign {en_s, sup_s, tick_s, pwm_s, ov_s, uv_s,
          half_s, oc_s, node_s, lg_s} = syn;

  // ============================================================
  // Sequencer state
  bps_state_t  state_q, state_d;
  logic [10:0] cnt_q, cnt_d;
  logic [10:0] ref_q, ref_d;
  logic [1:0]  pg_cnt_q, pg_cnt_d;
  logic [2:0]  oc_cnt_q, oc_cnt_d;
  logic        oc_seen_q, oc_seen_d;
  logic        oc_hold_q, oc_hold_d;
  logic        ov_hold_q, ov_hold_d;
  logic        first_q, first_d;
  logic        guard_q, guard_d;
  logic        uvf_q, uvf_d, ovf_q, ovf_d, ocf_q, ocf_d;
  logic        en_prev_q;
  logic        pg_q, pg_d;
  logic        hs_want, ls_want;
  logic        en_rise;

  assign en_rise = en_s && !en_prev_q;

  // Next-state logic of the sequence, protections and drive wishes.
  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    ref_d     = ref_q;
    pg_cnt_d  = pg_cnt_q;
    oc_cnt_d  = oc_cnt_q;
    oc_seen_d = oc_seen_q;
    oc_hold_d = oc_hold_q;
    ov_hold_d = ov_hold_q;
    first_d   = first_q;
    guard_d   = guard_q;
    uvf_d     = uvf_q;
    ovf_d     = ovf_q;
    ocf_d     = ocf_q;
    hs_want   = 1'b0;
    ls_want   = 1'b0;
    if (state_q != BPS_ST_OFF && !(en_s && sup_s)) begin
      state_d = BPS_ST_OFF; // RULE12
      ls_want = ov_s;
    end else begin
      unique case (state_q)
        BPS_ST_OFF: begin
          uvf_d     = 1'b0; // RULE12
          ovf_d     = 1'b0;
          ocf_d     = 1'b0;
          ov_hold_d = 1'b0;
          oc_hold_d = 1'b0;
          cnt_d     = `BPS_CNT_RESET;
          ref_d     = `BPS_REF_RESET;
          if (ov_s) begin
            guard_d = 1'b1; // RULE6
          end
          ls_want = guard_q || ov_s; // RULE6
          if (en_rise) begin
            guard_d = 1'b0; // RULE7
          end
          if (en_s && sup_s) begin
            state_d  = BPS_ST_DELAY; // RULE7
            guard_d  = 1'b0;
            first_d  = 1'b0;
            oc_cnt_d = 3'h0;
            oc_seen_d = 1'b0;
            ls_want  = 1'b0;
          end
        end
        BPS_ST_DELAY: begin
          if (tick_s) begin
            cnt_d = cnt_q + 11'h001;
            if (cnt_q == SS_DELAY_TICKS - 11'h001) begin
              state_d = BPS_ST_RAMP; // RULE15
              cnt_d   = `BPS_CNT_RESET;
            end
          end
        end
        BPS_ST_RAMP, BPS_ST_PG_WAIT, BPS_ST_RUN: begin
          // Loop drive, with low side masked until the first pulse.
          hs_want = pwm_s && !oc_s && !oc_hold_q;
          ls_want = oc_s || oc_hold_q || (!pwm_s && first_q); // RULE10 RULE17
          if (pwm_s) begin
            first_d = 1'b1; // RULE17
          end
          // Hold the low side until the next tick after an overcurrent.
          if (oc_s) begin
            oc_hold_d = 1'b1; // RULE10
          end else if (tick_s) begin
            oc_hold_d = 1'b0;
          end
          if (tick_s) begin
            oc_seen_d = 1'b0;
            oc_cnt_d  = (oc_seen_q || oc_s) ? oc_cnt_q + 3'h1 : 3'h0; // RULE18
          end else begin
            oc_seen_d = oc_seen_q || oc_s;
          end
          if (state_q == BPS_ST_RAMP && tick_s) begin
            cnt_d = cnt_q + 11'h001;
            ref_d = cnt_q + 11'h001; // RULE15
            if (cnt_q == SS_RAMP_TICKS - 11'h001) begin
              state_d  = BPS_ST_PG_WAIT;
              pg_cnt_d = 2'h0;
            end
          end
          if (state_q == BPS_ST_PG_WAIT && tick_s) begin
            pg_cnt_d = pg_cnt_q + 2'h1;
            if (pg_cnt_q == PG_DELAY_TICKS - 2'h1) begin
              state_d = BPS_ST_RUN; // RULE2
            end
          end
          if (uv_s) begin
            if (state_q != BPS_ST_RAMP) begin
              state_d = BPS_ST_FAULT; // RULE3
              uvf_d   = 1'b1;
            end else if (ref_q >= UV_ARM_LEVEL) begin // RULE16
              state_d = BPS_ST_DELAY; // RULE8
              cnt_d   = `BPS_CNT_RESET;
              ref_d   = `BPS_REF_RESET;
              first_d = 1'b0;
            end
          end
          if (oc_cnt_q == OC_LIMIT) begin
            state_d = BPS_ST_FAULT; // RULE11
            ocf_d   = 1'b1;
          end
        end
        BPS_ST_FAULT: begin
          if (half_s && !ov_s) begin
            ov_hold_d = 1'b0; // RULE4
          end
          ls_want = ov_s || ov_hold_q; // RULE5
        end
        default: begin
          state_d = BPS_ST_OFF;
        end
      endcase
      // Overvoltage is checked in every enabled state and wins.
      if (state_q != BPS_ST_OFF && ov_s) begin
        state_d   = BPS_ST_FAULT; // RULE4
        ovf_d     = 1'b1;
        ov_hold_d = 1'b1;
      end
      if (state_d == BPS_ST_FAULT) begin
        hs_want = 1'b0; // RULE3 RULE11
        ls_want = ov_s || (ov_hold_q && state_q == BPS_ST_FAULT);
      end
    end
    pg_d = (state_d == BPS_ST_RUN) && !ov_s && !uv_s; // RULE1 RULE9
  end

  // Sequencer registers.
  always_ff @(posedge clk_sys or negedge rst_n_q2) begin
    if (!rst_n_q2) begin
      state_q   <= BPS_ST_OFF;
      cnt_q     <= `BPS_CNT_RESET;
      ref_q     <= `BPS_REF_RESET;
      pg_cnt_q  <= 2'h0;
      oc_cnt_q  <= 3'h0;
      oc_seen_q <= 1'b0;
      oc_hold_q <= 1'b0;
      ov_hold_q <= 1'b0;
      first_q   <= 1'b0;
      guard_q   <= 1'b0;
      uvf_q     <= 1'b0;
      ovf_q     <= 1'b0;
      ocf_q     <= 1'b0;
      en_prev_q <= 1'b0;
      pg_q      <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      ref_q     <= ref_d;
      pg_cnt_q  <= pg_cnt_d;
      oc_cnt_q  <= oc_cnt_d;
      oc_seen_q <= oc_seen_d;
      oc_hold_q <= oc_hold_d;
      ov_hold_q <= ov_hold_d;
      first_q   <= first_d;
      guard_q   <= guard_d;
      uvf_q     <= uvf_d;
      ovf_q     <= ovf_d;
      ocf_q     <= ocf_d;
      en_prev_q <= en_s;
      pg_q      <= pg_d;
    end
  end

  // ============================================================
  // Dead-time control and watchdog
  logic       hs_q, hs_d, ls_q, ls_d;
  logic       node_wait_q, node_wait_d, lg_wait_q, lg_wait_d;
  logic       node_ok, lg_ok;
  logic [7:0] wd_q, wd_d;

  // High side waits for a low gate; low side waits for the node or dog.
  // A sense level counts only once it has shown the switched state since
  // its switch went on, so a stale synchronised level cannot open early.
  always_comb begin
    node_wait_d = node_wait_q;
    lg_wait_d   = lg_wait_q;
    if (!node_s) begin
      node_wait_d = 1'b0;
    end else if (hs_q) begin
      node_wait_d = 1'b1; // RULE13
    end
    if (!lg_s) begin
      lg_wait_d = 1'b0;
    end else if (ls_q) begin
      lg_wait_d = 1'b1; // RULE13
    end
    node_ok = node_s && !node_wait_q;
    lg_ok   = lg_s && !lg_wait_q;
    hs_d = hs_want && !ls_q && lg_ok; // RULE13
    wd_d = 8'h00;
    if (ls_want && !hs_q && !ls_q && !node_ok && wd_q != WDOG_CYCLES) begin
      wd_d = wd_q + 8'h01; // RULE14
    end else if (ls_want && !ls_q && wd_q == WDOG_CYCLES) begin
      wd_d = wd_q;
    end
    ls_d = ls_want && !hs_q &&
           (ls_q || node_ok || wd_q == WDOG_CYCLES); // RULE13 RULE14
  end

  // Gate command registers.
  always_ff @(posedge clk_sys or negedge rst_n_q2) begin
    if (!rst_n_q2) begin
      hs_q        <= 1'b0;
      ls_q        <= 1'b0;
      node_wait_q <= 1'b0;
      lg_wait_q   <= 1'b0;
      wd_q        <= 8'h00;
    end else begin
      hs_q        <= hs_d;
      ls_q        <= ls_d;
      node_wait_q <= node_wait_d;
      lg_wait_q   <= lg_wait_d;
      wd_q        <= wd_d;
    end
  end

  assign high_side_switch           = hs_q;
  assign low_side_switch            = ls_q;
  assign power_good_flag            = pg_q;
  assign reference_level            = ref_q;
  assign undervoltage_fault         = uvf_q;
  assign overvoltage_fault          = ovf_q;
  assign overcurrent_fault          = ocf_q;
  assign disabled_overvoltage_guard = guard_q;

  // ============================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n_q2);

  a_pg_window: // RULE1
    assert property (pg_q |-> $past(!ov_s && !uv_s))
      else $error("power good high with output outside window");
  a_pg_after_wait: // RULE2
    assert property ($rose(pg_q) |-> state_q == BPS_ST_RUN &&
                     ($past(state_q) == BPS_ST_PG_WAIT ||
                      $past(state_q) == BPS_ST_RUN))
      else $error("power good rose without the wait");
  a_uv_latch: // RULE3
    assert property ((state_q == BPS_ST_RUN && uv_s && en_s && sup_s)
                     |=> state_q == BPS_ST_FAULT && uvf_q ##1 !hs_q)
      else $error("undervoltage did not latch off");
  a_ov_takes_low: // RULE4
    assert property ((state_q == BPS_ST_RUN && ov_s && en_s && sup_s)
                     |=> ovf_q && ov_hold_q && !hs_q)
      else $error("overvoltage not latched");
  a_fault_ov_low: // RULE5
    assert property ((state_q == BPS_ST_FAULT && ov_s && en_s && sup_s &&
                      !hs_q) |=> ##[0:60] ls_q)
      else $error("low side not on for overvoltage in fault");
  a_guard_set: // RULE6
    assert property ((state_q == BPS_ST_OFF && ov_s && !en_s) |=> guard_q)
      else $error("disabled overvoltage guard not set");
  a_enable_clear: // RULE7
    assert property ((state_q == BPS_ST_OFF && en_rise && sup_s)
                     |=> !guard_q && state_q == BPS_ST_DELAY)
      else $error("enable edge did not clear guard");
  a_ss_restart: // RULE8
    assert property ((state_q == BPS_ST_RAMP && uv_s && !ov_s && en_s &&
                      sup_s && ref_q >= UV_ARM_LEVEL && oc_cnt_q != OC_LIMIT)
                     |=> state_q == BPS_ST_DELAY && ref_q == 11'h000)
      else $error("undervoltage in soft start did not restart");
  a_pg_drop: // RULE9
    assert property ($fell(pg_q) && state_q == BPS_ST_FAULT |->
                     ovf_q || uvf_q || ocf_q)
      else $error("power good fell late against fault");
  a_oc_no_high: // RULE10
    assert property (oc_s |=> !hs_q ##1 !hs_q)
      else $error("high side on during overcurrent");
  a_oc_latch: // RULE11
    assert property ((state_q == BPS_ST_RUN && oc_cnt_q == OC_LIMIT &&
                      en_s && sup_s) |=> state_q == BPS_ST_FAULT && ocf_q)
      else $error("seven overcurrent cycles did not latch");
  a_hs_dead: // RULE13
    assert property ($rose(hs_q) |-> $past(!ls_q && lg_s))
      else $error("high side rose without dead time");

endmodule : bps_sequencer

`default_nettype wire

// *** hw/bps_sync.sv ***
// Two-stage synchroniser for a group of comparator levels.
// Assumes an active-low reset already released in step with the clock.
`timescale 1ns/1ps
`default_nettype none

module bps_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Levels in and out.
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  // ============================================================
  // Stages
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] q_d;

  // The first stage feeds only the second one.
  always_comb begin
    meta_d = d;
    q_d    = meta_q;
  end

  // Both stages clear to zero under reset.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= meta_d;
      q      <= q_d;
    end
  end

endmodule : bps_sync

`default_nettype wire

// *** verification/bps_power_stage.sv ***
// Behavioural model of the switch pair, switch node and low gate sense.
// Assumes the sequencer's registered gate commands on the same clock.
`timescale 1ns/1ps
`default_nettype none

module bps_power_stage (
  // Clock.
  input  wire logic clk_sys,
  // Gate commands from the sequencer.
  input  wire logic high_side_switch,
  input  wire logic low_side_switch,
  // Negative inductor current keeps the node high after turn-off.
  input  wire logic neg_current,
  // Sense levels back to the sequencer.
  output logic      switch_node_low,
  output logic      low_gate_drive_low
);
  // ============================================================
  // Gate and node delays
  logic [1:0] gate_q = 2'h0;
  logic [2:0] node_q = 3'h0;

  // The low gate discharges two cycles after turn-off, and the node falls
  // three cycles after high-side turn-off unless the current is negative.
  always @(posedge clk_sys) begin
    gate_q <= {gate_q[0], ~low_side_switch};
    node_q <= {node_q[1:0],
               low_side_switch | (~high_side_switch & ~neg_current)};
  end

  assign low_gate_drive_low = gate_q[1];
  assign switch_node_low    = node_q[2];
endmodule : bps_power_stage
`default_nettype wire

// *** verification/test_buck_protection_sequencer.sv ***
// Self-checking bench of the buck protection sequencer.
// Assumes the sequencer and the power stage model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module test_buck_protection_sequencer;
  // ============================================================
  // Signals
  localparam logic [10:0] RAMP = 11'd16;
  typedef struct {int s; logic [10:0] e;} bps_note_t;
  logic        clk_sys, nrst, enable_in, supply_ok, pwm_demand;
  logic        switch_tick = 1'b0;
  logic [2:0]  tick_cnt    = 3'h0;
  logic        ovr, und, hlf, ocs, neg_i;
  logic        high_side_switch, low_side_switch, power_good_flag;
  logic        undervoltage_fault, overvoltage_fault, overcurrent_fault;
  logic        disabled_overvoltage_guard;
  logic        switch_node_low, low_gate_drive_low;
  logic [10:0] reference_level;
  logic [6:0]  flags;
  int          num_errors = 0;
  int          n_tests    = 0;
  int          cycles     = 0;
  integer      seed;
  bps_note_t   notes[$];
  bps_note_t   cur;
  event        got;
  string       names[8] = '{"high side", "low side", "power good",
    "undervoltage", "overvoltage", "overcurrent", "guard", "reference"};

  assign flags = {disabled_overvoltage_guard, overcurrent_fault,
                  overvoltage_fault, undervoltage_fault, power_good_flag,
                  low_side_switch, high_side_switch};

  // ============================================================
  // Design and power stage
  bps_sequencer #(
    .SS_DELAY_TICKS(RAMP),
    .SS_RAMP_TICKS (RAMP),
    .UV_ARM_LEVEL  (11'd13)
  ) u_bps_sequencer (
    .clk_sys, .nrst, .enable_in, .supply_ok, .switch_tick, .pwm_demand,
    .output_sense_over      (ovr),
    .output_sense_under     (und),
    .output_sense_below_half(hlf),
    .current_sense_over     (ocs),
    .switch_node_low, .low_gate_drive_low, .high_side_switch,
    .low_side_switch, .power_good_flag, .reference_level,
    .undervoltage_fault, .overvoltage_fault, .overcurrent_fault,
    .disabled_overvoltage_guard
  );

  bps_power_stage u_bps_power_stage (
    .clk_sys, .high_side_switch, .low_side_switch,
    .neg_current(neg_i), .switch_node_low, .low_gate_drive_low
  );

  // ============================================================
  // Clock, switching tick and timeout
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // A tick every eighth cycle; a hung run is cut short.
  always @(posedge clk_sys) begin
    tick_cnt    <= tick_cnt + 3'h1;
    switch_tick <= (tick_cnt == 3'h7);
    cycles      <= cycles + 1;
    if (cycles == 12000) begin
      num_errors++;
      end_of_test();
    end
  end

  // ============================================================
  // Checking
  function automatic logic [10:0] obs(input int s);
    return (s == 7) ? reference_level : {10'h000, flags[s]};
  endfunction : obs

  task automatic check(input string nm, input logic [10:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : check

  // Waits one cycle and up to n more for output s to reach e (no wait if n is negative), then files a note.
  task automatic chk(input int s, input logic [10:0] e, input int n);
    if (n >= 0) @(negedge clk_sys);
    for (int i = 0; i < n && obs(s) !== e; i++) @(negedge clk_sys);
    notes.push_back('{s, e});
    -> got;
  endtask : chk

  // Compares each note against the output it names, oldest first.
  always @(got) begin
    while (notes.size() > 0) begin
      cur = notes.pop_front();
      check(names[cur.s], obs(cur.s), cur.e);
    end
  end

  // Both switches on together would short the input supply.
  always @(negedge clk_sys) begin
    if (high_side_switch === 1'b1 && low_side_switch === 1'b1) begin
      check("overlap", 11'h001, 11'h000);
    end
  end

  task automatic fin(input string s);
    $display("test %s done", s);
  endtask : fin

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  // ============================================================
  // Sequences shared by the tests
  task automatic off();
    @(posedge clk_sys);
    enable_in  <= 1'b0;
    hlf        <= 1'b0;
    pwm_demand <= 1'b0;
    chk(3, 11'h000, 8);
    chk(4, 11'h000, 8);
    chk(5, 11'h000, 8);
  endtask : off

  task automatic on();
    @(posedge clk_sys);
    enable_in <= 1'b1;
    chk(6, 11'h000, 8);
    chk(1, 11'h000, 8);
  endtask : on

  // Power-good must not rise early, then must rise with a full reference.
  task automatic good();
    repeat (258) @(posedge clk_sys);
    chk(2, 11'h000, 0);
    chk(1, 11'h000, -1);
    chk(2, 11'h001, 60);
    chk(7, RAMP, -1);
  endtask : good

  task automatic run_high();
    @(posedge clk_sys);
    pwm_demand <= 1'b1;
    chk(0, 11'h001, 12);
  endtask : run_high

  // ============================================================
  // Main sequence
  initial begin
    seed = 32'h209798c3;
    {nrst, enable_in, supply_ok, pwm_demand} = 4'h0;
    {ovr, und, hlf, ocs, neg_i} = 5'h00;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int s = 0; s < 8; s++) chk(s, 11'h000, 0);
    fin("reset");
    @(posedge clk_sys);
    supply_ok <= 1'b1;
    ovr       <= 1'b1;
    chk(6, 11'h001, 8);
    chk(1, 11'h001, 3);
    @(posedge clk_sys);
    ovr <= 1'b0;
    repeat (10) @(posedge clk_sys);
    chk(6, 11'h001, 0);
    on();
    good();
    fin("guard and soft-start");
    repeat (300) begin
      @(posedge clk_sys);
      pwm_demand <= 1'($random(seed));
    end
    run_high();
    @(posedge clk_sys);
    pwm_demand <= 1'b0;
    chk(1, 11'h001, 12);
    run_high();
    @(posedge clk_sys);
    pwm_demand <= 1'b0;
    neg_i      <= 1'b1;
    repeat (30) @(posedge clk_sys);
    chk(1, 11'h000, 0);
    chk(1, 11'h001, 40);
    @(posedge clk_sys);
    neg_i <= 1'b0;
    fin("dead time");
    run_high();
    @(posedge clk_sys);
    ocs <= 1'b1;
    chk(1, 11'h001, 12);
    chk(0, 11'h000, -1);
    // Runs of at most six ticks, each followed by a clean tick.
    repeat (2) begin
      @(posedge clk_sys);
      ocs <= 1'b0;
      repeat (24) @(posedge clk_sys);
      ocs <= 1'b1;
      repeat (40) @(posedge clk_sys);
    end
    ocs <= 1'b0;
    repeat (24) @(posedge clk_sys);
    chk(5, 11'h000, 0);
    @(posedge clk_sys);
    ocs <= 1'b1;
    chk(5, 11'h001, 90);
    chk(0, 11'h000, -1);
    @(posedge clk_sys);
    ocs <= 1'b0;
    chk(1, 11'h000, 8);
    @(posedge clk_sys);
    ovr <= 1'b1;
    chk(1, 11'h001, 6);
    @(posedge clk_sys);
    ovr <= 1'b0;
    hlf <= 1'b1;
    chk(1, 11'h000, 8);
    fin("overcurrent");
    off();
    on();
    good();
    run_high();
    @(posedge clk_sys);
    und <= 1'b1;
    chk(3, 11'h001, 6);
    chk(2, 11'h000, -1);
    chk(0, 11'h000, -1);
    chk(1, 11'h000, -1);
    @(posedge clk_sys);
    und        <= 1'b0;
    supply_ok  <= 1'b0;
    pwm_demand <= 1'b0;
    chk(3, 11'h000, 8);
    @(posedge clk_sys);
    supply_ok <= 1'b1;
    good();
    fin("undervoltage");
    run_high();
    @(posedge clk_sys);
    ovr <= 1'b1;
    chk(4, 11'h001, 6);
    chk(2, 11'h000, -1);
    chk(0, 11'h000, -1);
    chk(1, 11'h001, 8);
    @(posedge clk_sys);
    ovr <= 1'b0;
    repeat (10) @(posedge clk_sys);
    chk(1, 11'h001, 0);
    @(posedge clk_sys);
    hlf <= 1'b1;
    chk(1, 11'h000, 6);
    fin("overvoltage");
    off();
    on();
    repeat (20) @(posedge clk_sys);
    und <= 1'b1;
    repeat (40) @(posedge clk_sys);
    und <= 1'b0;
    chk(3, 11'h000, 0);
    // Undervoltage early in the ramp must leave the ramp running.
    chk(7, 11'd4, 300);
    @(posedge clk_sys);
    und <= 1'b1;
    repeat (40) @(posedge clk_sys);
    und <= 1'b0;
    chk(3, 11'h000, 0);
    chk(7, 11'd14, 60);
    @(posedge clk_sys);
    und <= 1'b1;
    chk(7, 11'h000, 8);
    chk(3, 11'h000, -1);
    @(posedge clk_sys);
    und <= 1'b0;
    good();
    fin("soft-start undervoltage");
    end_of_test();
  end
endmodule : test_buck_protection_sequencer
`default_nettype wire
